//--- can_mode_timer_pkg.sv
// package for the transceiver mode and wake timer block
// assumes a single 125 MHz core clock; no software registers
package can_mode_timer_pkg;
  localparam int unsigned CLK_MHZ = 125;
  // times in their own units, figures as printed
  localparam int unsigned UV_FILTER_MS = 100;        // least of 100..350 ms
  localparam int unsigned UV_REENABLE_US = 200;
  localparam int unsigned WAKE_FILTER_NS = 500;      // least of 0.5..1.8 us
  localparam int unsigned SILENCE_MS = 600;          // least of 0.6..1.2 s
  localparam int unsigned IDLE_MIN = 4;              // nominal, 3..5 min
  localparam int unsigned LOCAL_WAKE_US = 5;         // least of 5..50 us
  localparam int unsigned SUPPLY_ON_US = 100;
  localparam int unsigned MASK_HOLD_US = 50;
  localparam int unsigned MODE1_US = 20;
  localparam int unsigned MODE2_US = 10;
  localparam int unsigned SLEEP_HOLD_US = 20;        // least of 20..50 us
  // derived cycle counts
  localparam longint unsigned UV_FILTER_CYC = UV_FILTER_MS * CLK_MHZ * 1000;
  localparam longint unsigned SILENCE_CYC = SILENCE_MS * CLK_MHZ * 1000;
  localparam longint unsigned IDLE_CYC =
    64'(IDLE_MIN) * 60 * 1000000 * CLK_MHZ;
  localparam int unsigned WAKE_FILTER_CYC = (WAKE_FILTER_NS * CLK_MHZ + 999)
    / 1000;
  localparam int unsigned LOCAL_WAKE_CYC = LOCAL_WAKE_US * CLK_MHZ;
  localparam int unsigned MASK_HOLD_CYC = MASK_HOLD_US * CLK_MHZ;
  localparam int unsigned SLEEP_HOLD_CYC = SLEEP_HOLD_US * CLK_MHZ;
  localparam int unsigned WAKE_EDGES = 2;            // dominant then recessive
  localparam int CW = 36;                            // counter width
  typedef enum logic [1:0] {MODE_NORMAL, MODE_SILENT, MODE_STANDBY,
    MODE_SLEEP} mode_type;
endpackage

//--- can_mode_timers.sv
// mode and wake timing control of a can transceiver
// assumes all pin inputs are asynchronous levels; one core clock
// Functional notes
// - a supply undervoltage counts only once it persists 100 ms or more.
// - once undervoltage clears, operation resumes within 200 us.
// - a bus phase counts toward the wake pattern only if long enough.
// - a silence timer of 0.6 s restarts on every bus transition.
// - a standby idle timer of nominally 4 minutes runs after power-up.
// - a local wake needs the wake pin stable 5 us after an edge.
// - after a wake event the supply control rises within 100 us.
// - the supply mask is applied only after its input held 50 us.
// - leaving sleep, enter normal or silent within 20 us of supplies.
// - mode changes among normal, silent, standby finish within 10 us.
// - sleep is entered after enable high, standby low held 20 us.
`timescale 1ns/100ps
module can_mode_timers #(
  parameter longint unsigned UV_FILT = can_mode_timer_pkg::UV_FILTER_CYC,
  parameter longint unsigned SILENCE = can_mode_timer_pkg::SILENCE_CYC,
  parameter longint unsigned IDLE = can_mode_timer_pkg::IDLE_CYC,
  parameter int unsigned LWAKE = can_mode_timer_pkg::LOCAL_WAKE_CYC,
  parameter int unsigned MHOLD = can_mode_timer_pkg::MASK_HOLD_CYC,
  parameter int unsigned SHOLD = can_mode_timer_pkg::SLEEP_HOLD_CYC
) (
  input wire logic i_core_clk, // 125 mhz core clock
  input wire logic i_rst_n, // synchronous reset, active low
  input wire logic i_core_uv, // core supply below threshold
  input wire logic i_io_uv, // io supply below threshold
  input wire logic i_bus_dominant, // receiver sees dominant bus
  input wire logic i_wake_pin, // local wake pin level
  input wire logic i_enable, // host enable pin
  input wire logic i_standby_select_n, // host standby select, active low
  input wire logic i_supply_control_hold_in, // supply control mask pin
  output logic [1:0] o_mode, // current mode code
  output logic o_supply_control_out, // supply control output
  output logic o_uv_fault, // filtered undervoltage
  output logic o_bus_wake_pattern, // pulse: bus wake recognised
  output logic o_local_pin_wake_event, // pulse: local wake recognised
  output logic o_bus_silent // bus silence timeout reached
);
  localparam int CW = can_mode_timer_pkg::CW;
  localparam logic [CW-1:0] UV_C = CW'(UV_FILT);
  localparam logic [CW-1:0] SIL_C = CW'(SILENCE);
  localparam logic [CW-1:0] IDLE_C = CW'(IDLE);
  localparam logic [CW-1:0] LW_C = CW'(LWAKE);
  localparam logic [CW-1:0] MH_C = CW'(MHOLD);
  localparam logic [CW-1:0] SH_C = CW'(SHOLD);
  localparam logic [CW-1:0] WF_C = CW'(can_mode_timer_pkg::WAKE_FILTER_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [5:0] s1; // first sync stage of six pins
    logic [5:0] s2; // second sync stage
    logic mask_s1; // mask pin first sync stage
    logic mask_s2; // mask pin second sync stage
    logic [CW-1:0] uv_cnt;
    logic [CW-1:0] bus_cnt;
    logic [CW-1:0] sil_cnt;
    logic [CW-1:0] idle_cnt;
    logic [CW-1:0] lw_cnt;
    logic [CW-1:0] mh_cnt;
    logic [CW-1:0] sl_cnt;
    logic bus_prev;
    logic [1:0] wup_step;
    logic wake_prev;
    logic lw_armed;
    logic mask_q; // qualified mask level
    logic idle_run;
    can_mode_timer_pkg::mode_type mode;
    logic supply_control_out;
    logic uv;
    logic bus_wake_pattern;
    logic local_pin_wake_event;
    logic silent;
  } state_type;

  state_type cur, next_cur;
  logic [5:0] pins;
  assign pins = {i_core_uv, i_io_uv, i_bus_dominant, i_wake_pin, i_enable,
                 i_standby_select_n};

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic; s2 bits: 5 core uv, 4 io uv, 3 bus, 2 wake, 1 en, 0 stb
  always_comb
  begin
    logic any_uv;
    logic host_sleep;
    can_mode_timer_pkg::mode_type req;
    any_uv = 1'b0;
    host_sleep = 1'b0;
    req = can_mode_timer_pkg::MODE_STANDBY;
    next_cur = cur;
    next_cur.s1 = pins;
    next_cur.s2 = cur.s1; // only the second stage feeds logic
    next_cur.mask_s1 = i_supply_control_hold_in;
    next_cur.mask_s2 = cur.mask_s1;
    next_cur.bus_wake_pattern = 1'b0;
    next_cur.local_pin_wake_event = 1'b0;
    any_uv = cur.s2[5] | cur.s2[4];
    // filter: counter only reaches the limit after a steady low supply
    if (!any_uv)
    begin
      next_cur.uv_cnt = '0;
      next_cur.uv = 1'b0; // clears next cycle, well inside 200 us
    end
    else if (cur.uv_cnt >= UV_C)
      next_cur.uv = 1'b1;
    else
      next_cur.uv_cnt = cur.uv_cnt + ONE;
    // bus phase filter and wake pattern: long dominant then long recessive
    if (cur.s2[3] != cur.bus_prev)
      next_cur.bus_cnt = '0;
    else if (cur.bus_cnt < WF_C)
      next_cur.bus_cnt = cur.bus_cnt + ONE;
    next_cur.bus_prev = cur.s2[3];
    if (cur.bus_cnt == WF_C - ONE && cur.s2[3] == cur.bus_prev)
    begin
      // phase qualified: dominant moves step 0, recessive step 1
      if (cur.s2[3] == !cur.wup_step[0] &&
          cur.wup_step != 2'(can_mode_timer_pkg::WAKE_EDGES))
        next_cur.wup_step = cur.wup_step + 2'd1;
    end
    if (cur.wup_step == 2'(can_mode_timer_pkg::WAKE_EDGES))
    begin
      next_cur.wup_step = '0;
      next_cur.bus_wake_pattern = cur.mode == can_mode_timer_pkg::MODE_SLEEP;
    end
    // a half pattern seen while awake must not finish a wake in sleep
    if (cur.mode != can_mode_timer_pkg::MODE_SLEEP)
      next_cur.wup_step = '0;
    // silence timer restarts on any transition
    if (cur.s2[3] != cur.bus_prev)
      next_cur.sil_cnt = '0;
    else if (cur.sil_cnt < SIL_C)
      next_cur.sil_cnt = cur.sil_cnt + ONE;
    next_cur.silent = cur.sil_cnt >= SIL_C;
    // local wake: pin must stay steady after an edge
    next_cur.wake_prev = cur.s2[2];
    if (cur.s2[2] != cur.wake_prev)
    begin
      next_cur.lw_cnt = '0;
      next_cur.lw_armed = 1'b1;
    end
    else if (cur.lw_armed && cur.lw_cnt >= LW_C - ONE)
    begin
      next_cur.lw_armed = 1'b0;
      next_cur.local_pin_wake_event = cur.mode == can_mode_timer_pkg::MODE_SLEEP;
    end
    else if (cur.lw_armed)
      next_cur.lw_cnt = cur.lw_cnt + ONE;
    // mask qualification; a change shorter than the hold is ignored
    if (cur.mask_s2 == cur.mask_q)
      next_cur.mh_cnt = '0;
    else if (cur.mh_cnt >= MH_C - ONE)
      next_cur.mask_q = cur.mask_s2; // held 50 us before acting
    else
      next_cur.mh_cnt = cur.mh_cnt + ONE;
    // host sleep request qualified by hold time
    host_sleep = cur.s2[1] && !cur.s2[0];
    if (!host_sleep)
      next_cur.sl_cnt = '0;
    else if (cur.sl_cnt < SH_C)
      next_cur.sl_cnt = cur.sl_cnt + ONE;
    // requested mode from the pins
    case ({cur.s2[1], cur.s2[0]})
      2'b11: req = can_mode_timer_pkg::MODE_NORMAL;
      2'b01: req = can_mode_timer_pkg::MODE_SILENT;
      default: req = can_mode_timer_pkg::MODE_STANDBY;
    endcase
    // idle timer from power-up, stopped by a host request for normal or silent
    if (cur.idle_run && req != can_mode_timer_pkg::MODE_STANDBY)
      next_cur.idle_run = 1'b0;
    else if (cur.idle_run)
      next_cur.idle_cnt = cur.idle_cnt + ONE;
    // mode machine; changes take one cycle, inside 10 us and 20 us
    case (cur.mode)
      can_mode_timer_pkg::MODE_SLEEP:
      begin
        if (cur.bus_wake_pattern || cur.local_pin_wake_event)
          next_cur.mode = can_mode_timer_pkg::MODE_STANDBY;
        else if (!any_uv && req != can_mode_timer_pkg::MODE_STANDBY)
          next_cur.mode = req; // once supplies are up
      end
      default:
      begin
        if (cur.idle_run && cur.idle_cnt >= IDLE_C)
        begin
          next_cur.mode = can_mode_timer_pkg::MODE_SLEEP;
          next_cur.idle_run = 1'b0;
        end
        else if (cur.uv || cur.sl_cnt >= SH_C)
          next_cur.mode = can_mode_timer_pkg::MODE_SLEEP;
        else
          next_cur.mode = req;
      end
    endcase
    // supply control: off in sleep; a masked wake leaves it off in
    // standby until the host asks for normal or silent
    if (next_cur.mode == can_mode_timer_pkg::MODE_SLEEP)
      next_cur.supply_control_out = 1'b0;
    else if (cur.mode == can_mode_timer_pkg::MODE_SLEEP &&
             (cur.bus_wake_pattern || cur.local_pin_wake_event))
      next_cur.supply_control_out = !cur.mask_q; // inside 100 us
    else if (req != can_mode_timer_pkg::MODE_STANDBY)
      next_cur.supply_control_out = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; idle timer starts at reset release as power-up
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      cur <= '0; // zero sync stages read as a standby request, no edge
      cur.idle_run <= 1'b1;
      cur.supply_control_out <= 1'b1;
      cur.mode <= can_mode_timer_pkg::MODE_STANDBY;
    end
    else
      cur <= next_cur;
  end

  assign o_mode = cur.mode;
  assign o_supply_control_out = cur.supply_control_out;
  assign o_uv_fault = cur.uv;
  assign o_bus_wake_pattern = cur.bus_wake_pattern;
  assign o_local_pin_wake_event = cur.local_pin_wake_event;
  assign o_bus_silent = cur.silent;
endmodule // can_mode_timers

//--- can_mode_monitor.sv
// checker for the mode and wake timer block
// sees only the block ports; attached by the bind at the foot
`timescale 1ns/100ps
module can_mode_monitor #(
  parameter longint unsigned UV_FILT = 40, // undervoltage filter cycles
  parameter longint unsigned SILENCE = 60, // silence timeout cycles
  parameter int unsigned LWAKE = 20, // local wake filter cycles
  parameter int unsigned SHOLD = 25 // sleep entry hold cycles
) (
  input wire logic i_core_clk, i_rst_n, i_core_uv, i_io_uv, // clock, supplies
  input wire logic i_bus_dominant, i_wake_pin, i_enable, // bus and pins
  input wire logic i_standby_select_n, i_supply_control_hold_in, // pins
  input wire logic [1:0] o_mode, // mode code
  input wire logic o_supply_control_out, o_uv_fault, o_bus_wake_pattern,
  input wire logic o_local_pin_wake_event, o_bus_silent // events
);
  logic [31:0] uvc, bsc, wkc, slc;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////////////
  // run lengths of input conditions; raw pins, so the design's own
  // synchroniser delay only adds margin
  always_ff @(posedge i_core_clk)
  begin
    uvc <= (!i_rst_n || !(i_core_uv | i_io_uv)) ? '0 : uvc + 1;
    bsc <= (!i_rst_n || $changed(i_bus_dominant)) ? '0 : bsc + 1;
    wkc <= (!i_rst_n || $changed(i_wake_pin)) ? '0 : wkc + 1;
    slc <= (!i_rst_n || !(i_enable & !i_standby_select_n)) ? '0 : slc + 1;
  end
  //////////////////////////////////////////////////////////////////////
  a_uv_filter: assert property ($rose(o_uv_fault) |-> uvc >= UV_FILT)
    else $error("undervoltage flagged too early");
  a_uv_clear: assert property ($fell(i_core_uv | i_io_uv) && o_uv_fault
    |-> ##[1:1000] !o_uv_fault) else $error("undervoltage not cleared");
  a_bus_wake: assert property (o_bus_wake_pattern
    |-> !i_bus_dominant && bsc >= can_mode_timer_pkg::WAKE_FILTER_CYC)
    else $error("bus wake from short phase");
  a_local_wake: assert property (o_local_pin_wake_event |-> wkc >= LWAKE)
    else $error("local wake from short level");
  a_supply_wake: assert property ((o_bus_wake_pattern | o_local_pin_wake_event)
    && !i_supply_control_hold_in |-> ##[0:8] o_supply_control_out)
    else $error("supply control not raised");
  a_mask_hold: assert property (o_local_pin_wake_event && i_supply_control_hold_in
    && !o_supply_control_out |=> !o_supply_control_out[*4])
    else $error("masked supply control raised");
  a_silence_min: assert property ($rose(o_bus_silent) |-> bsc >= SILENCE)
    else $error("silence flagged too early");
  a_sleep_hold: assert property ($rose(o_mode == 2'h3) && i_enable
    && !i_standby_select_n && !o_uv_fault |-> slc >= SHOLD)
    else $error("sleep entered before hold");
  a_sleep_exit: assert property (o_mode == 2'h3 && i_enable
    && i_standby_select_n && !i_core_uv && !i_io_uv |-> ##[1:1000] o_mode == 2'h0)
    else $error("sleep not left for normal");
  a_to_standby: assert property (!i_enable && !i_standby_select_n
    && o_mode < 2'h2 |-> ##[1:8] o_mode == 2'h2) else $error("standby late");
  c_bus_wake: cover property (o_bus_wake_pattern);
  c_local_wake: cover property (o_local_pin_wake_event);
  c_silent: cover property ($rose(o_bus_silent));
endmodule // can_mode_monitor
bind can_mode_timers can_mode_monitor #(.UV_FILT(UV_FILT), .SILENCE(SILENCE),
  .LWAKE(LWAKE), .SHOLD(SHOLD)) can_mode_monitor_inst (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_core_uv(i_core_uv),
  .i_io_uv(i_io_uv), .i_bus_dominant(i_bus_dominant),
  .i_wake_pin(i_wake_pin), .i_enable(i_enable),
  .i_standby_select_n(i_standby_select_n),
  .i_supply_control_hold_in(i_supply_control_hold_in),
  .o_mode(o_mode), .o_supply_control_out(o_supply_control_out),
  .o_uv_fault(o_uv_fault), .o_bus_wake_pattern(o_bus_wake_pattern),
  .o_local_pin_wake_event(o_local_pin_wake_event),
  .o_bus_silent(o_bus_silent));

//--- host_model.sv
// host model driving the mode and mask pins
// assumes one core clock; pins move one cycle after a request
`timescale 1ns/100ps
module host_model (
  input wire logic i_clk, // core clock
  input wire logic [1:0] i_req, // requested mode code
  input wire logic i_mask_req, // requested mask level
  output logic o_enable = 1'b0, // enable pin
  output logic o_standby_select_n = 1'b0, // standby select, active low
  output logic o_hold = 1'b0 // supply control mask pin
);
  // request taken at the edge, pins changed shortly after and held
  always @(posedge i_clk)
  begin
    o_enable <= #1 (i_req == 2'h0) || (i_req == 2'h3);
    o_standby_select_n <= #1 (i_req < 2'h2);
    o_hold <= #1 i_mask_req;
  end
endmodule // host_model

//--- testbench.sv
// bench for the mode and wake timer block, with short timer parameters
// host pins come from the host model; bus and wake pins driven here
`timescale 1ns/100ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin \
  mismatches++; $display("[FAIL] %s exp %0h got %0h", n, e, a); end end
module testbench;
  localparam int UVF = 40, SIL = 60, IDL = 400, LWK = 20, MHD = 30, SHD = 25;
  logic i_core_clk = 0, i_rst_n = 0, i_core_uv = 0, i_io_uv = 0;
  logic i_bus_dominant = 0, i_wake_pin = 0, mask = 0, bw = 0, lw = 0;
  logic i_enable, i_standby_select_n, i_supply_control_hold_in;
  logic o_supply_control_out, o_uv_fault, o_bus_wake_pattern, o_bus_silent;
  logic o_local_pin_wake_event;
  logic [1:0] req = 2'h2, o_mode;
  int mismatches = 0, num_checks = 0;
  always #4 i_core_clk = ~i_core_clk;
  can_mode_timers #(.UV_FILT(UVF), .SILENCE(SIL), .IDLE(IDL), .LWAKE(LWK),
    .MHOLD(MHD), .SHOLD(SHD)) can_mode_timers_inst (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_core_uv(i_core_uv),
    .i_io_uv(i_io_uv), .i_bus_dominant(i_bus_dominant),
    .i_wake_pin(i_wake_pin), .i_enable(i_enable),
    .i_standby_select_n(i_standby_select_n),
    .i_supply_control_hold_in(i_supply_control_hold_in),
    .o_mode(o_mode), .o_supply_control_out(o_supply_control_out),
    .o_uv_fault(o_uv_fault), .o_bus_wake_pattern(o_bus_wake_pattern),
    .o_local_pin_wake_event(o_local_pin_wake_event),
    .o_bus_silent(o_bus_silent));
  host_model host_model_inst (.i_clk(i_core_clk), .i_req(req),
    .i_mask_req(mask), .o_enable(i_enable),
    .o_standby_select_n(i_standby_select_n),
    .o_hold(i_supply_control_hold_in));
  // wake outputs are one-cycle pulses, so latch them for later checks
  always @(posedge i_core_clk)
  begin
    if (o_bus_wake_pattern) bw <= 1'b1;
    if (o_local_pin_wake_event) lw <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // bounded wait for a mode; running out ends the run
  task wait_mode(input logic [1:0] m, input int lim);
    int k;
    for (k = 0; k < lim && o_mode !== m; k++) cyc(1);
    `CHK("mode", m, o_mode)
    if (k == lim) conclude();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_idle_and_modes;
    cyc(IDL - 30);
    `CHK("idle mode", 2'h2, o_mode)
    wait_mode(2'h3, 60);
    req = 2'h0;
    wait_mode(2'h0, 1000);
    req = 2'h1;
    wait_mode(2'h1, 10);
    req = 2'h2;
    wait_mode(2'h2, 10);
    req = 2'h0;
    wait_mode(2'h0, 10);
  endtask
  task t_uv;
    i_core_uv = 1;
    cyc(UVF / 2);
    i_core_uv = 0;
    `CHK("short uv", 1'b0, o_uv_fault)
    cyc(5);
    i_core_uv = 1;
    cyc(UVF + 6);
    `CHK("long uv", 1'b1, o_uv_fault)
    wait_mode(2'h3, 10);
    i_core_uv = 0;
    cyc(8);
    `CHK("uv clear", 1'b0, o_uv_fault)
    wait_mode(2'h0, 1000);
  endtask
  task t_sleep_and_bus_wake;
    req = 2'h3;
    cyc(SHD / 2);
    req = 2'h0;
    cyc(SHD);
    `CHK("short hold", 2'h0, o_mode)
    req = 2'h3;
    wait_mode(2'h3, SHD + 12);
    req = 2'h2;
    i_bus_dominant = 1;
    cyc(30);
    i_bus_dominant = 0;
    cyc(30);
    `CHK("short phases", 1'b0, bw)
    i_bus_dominant = 1;
    cyc(80);
    i_bus_dominant = 0;
    cyc(80);
    `CHK("bus wake", 1'b1, bw)
    `CHK("supply on", 1'b1, o_supply_control_out)
    `CHK("wake mode", 2'h2, o_mode)
  endtask
  // mask flicker shorter than its hold must not lift the mask
  task t_local_wake;
    req = 2'h3;
    mask = 1;
    wait_mode(2'h3, SHD + 12);
    req = 2'h2;
    cyc(MHD + 10);
    mask = 0;
    cyc(MHD / 2);
    mask = 1;
    cyc(MHD + 10);
    i_wake_pin = 1;
    cyc(LWK - 4);
    `CHK("early wake", 1'b0, lw)
    cyc(14);
    `CHK("local wake", 1'b1, lw)
    `CHK("masked supply", 1'b0, o_supply_control_out)
  endtask
  task t_silence;
    i_bus_dominant = 1;
    cyc(SIL - 20);
    `CHK("not silent", 1'b0, o_bus_silent)
    cyc(30);
    `CHK("silent", 1'b1, o_bus_silent)
    i_bus_dominant = 0;
    cyc(6);
    `CHK("restart", 1'b0, o_bus_silent)
  endtask
  // second reset in mid-run: supply back on during reset, standby kept two cycles after release
  task t_reset;
    i_rst_n = 0;
    cyc(3);
    `CHK("reset supply", 1'b1, o_supply_control_out)
    i_rst_n = 1;
    cyc(2);
    `CHK("after reset", 2'h2, o_mode)
  endtask
  initial
  begin
    cyc(20);
    `CHK("reset mode", 2'h2, o_mode)
    i_rst_n = 1;
    t_idle_and_modes();
    t_uv();
    t_sleep_and_bus_wake();
    t_local_wake();
    t_silence();
    t_reset();
    conclude();
  end
endmodule // testbench
